// ### hw/hbm_pkg.sv
// Constants and types for the host bus mode and interrupt pin block.
// Assumes a single 125 MHz clock domain.
package hbm_pkg;
	localparam int unsigned CLK_PERIOD_NS  = 8;
	localparam int unsigned SYNC_STAGES    = 2;
	localparam int unsigned NUM_CHAN       = 2;
	localparam int unsigned CHAN_A         = 0;
	localparam int unsigned CHAN_B         = 1;
	localparam logic        MODE_SEL_WIDE  = 1'h1;
	localparam logic        DIR_READ       = 1'h1;
	localparam logic        STROBE_ACTIVE  = 1'h0;
	localparam logic        IRQ_ACTIVE_LOW = 1'h0;
	localparam logic        USER_OUT_LOW   = 1'h0;
	localparam logic        USER_OUT_HIGH  = 1'h1;

	typedef enum logic {
		hbm_mode_strobes,
		hbm_mode_direction
	} hbm_mode_type;

	typedef enum {
		hbm_st_idle,
		hbm_st_read,
		hbm_st_write
	} hbm_cycle_type;
endpackage

// ### hw/hbm_pins_if.sv
// Interface carrying synchronised host pin levels between modules.
// Assumes both ends run on mclk.
`timescale 1ns/1ps
`default_nettype none
interface hbm_pins_if;
	logic mode_sel;
	logic reset_pin;
	logic read_n;
	logic write_dir;
	logic chip_sel_n;
	modport src (output mode_sel, output reset_pin, output read_n,
		output write_dir, output chip_sel_n);
	modport dst (input mode_sel, input reset_pin, input read_n,
		input write_dir, input chip_sel_n);
endinterface
`default_nettype wire

// ### hw/hbm_sync.sv
// Two-stage synchroniser for every host pin entering mclk.
// Assumes pins are asynchronous to mclk.
`timescale 1ns/1ps
`default_nettype none
module hbm_sync
	import hbm_pkg::*;
(
	input  wire logic mclk,
	input  wire logic rst,
	input  wire logic mode_sel_pin,
	input  wire logic reset_pin,
	input  wire logic read_strobe_n,
	input  wire logic write_strobe_n,
	input  wire logic chip_sel_n,
	hbm_pins_if.src   pins
);
	localparam int unsigned W = 5;
	logic [W-1:0] meta_ff;
	logic [W-1:0] sync_ff;
	logic [W-1:0] raw;

	assign raw = {mode_sel_pin, reset_pin, read_strobe_n, write_strobe_n,
		chip_sel_n};

	// Idle value is high on every pin
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			meta_ff <= '1;
			sync_ff <= '1;
		end else begin
			meta_ff <= raw;
			sync_ff <= meta_ff;
		end
	end

	assign pins.mode_sel   = sync_ff[4];
	assign pins.reset_pin  = sync_ff[3];
	assign pins.read_n     = sync_ff[2];
	assign pins.write_dir  = sync_ff[1];
	assign pins.chip_sel_n = sync_ff[0];
endmodule
`default_nettype wire

// ### hw/hbm_top.sv
// Behaviour
// - Enable A: drive interrupt A, user out low
// - Disable A: interrupt A high impedance
// - Disable: user output two driven high
// - Enable B: drive interrupt B, user out low
// - Disable B: three-state interrupt B, output high
// - Mode high: second pin is channel B interrupt
// - Mode low: shared open-drain active-low interrupt
// - Mode low: channel B pin left undriven
// - Mode high: read strobe used, else ignored
// - Mode high: write strobe on shared pin
// - Mode low: shared pin is read/write direction
// - Reset polarity follows mode select
//
// Host pin mode logic and interrupt pin drivers for two channels.
// Assumes interrupt requests and enable bits come from mclk logic.
`timescale 1ns/1ps
`default_nettype none
module hbm_top
	import hbm_pkg::*;
(
	input  wire logic             mclk,
	input  wire logic             rst,
	input  wire logic             mode_sel_pin,
	input  wire logic             master_reset_pin,
	input  wire logic             read_strobe_n,
	input  wire logic             write_strobe_n,
	input  wire logic             chip_sel_n,
	input  wire logic [NUM_CHAN-1:0] interrupt_output_enable_bit,
	input  wire logic [NUM_CHAN-1:0] chan_irq_req,
	output logic                  chan_a_interrupt_out_o,
	output logic                  chan_a_interrupt_out_oe,
	output logic                  chan_b_interrupt_out_o,
	output logic                  chan_b_interrupt_out_oe,
	output logic                  chan_a_user_output_two,
	output logic                  chan_b_user_output_two,
	output logic                  mode_direction,
	output logic                  uart_reset,
	output logic                  reg_read_pulse,
	output logic                  reg_write_pulse,
	output logic                  cycle_active
);
	hbm_pins_if pins ();

	hbm_sync u_sync (
		.mclk           (mclk),
		.rst            (rst),
		.mode_sel_pin   (mode_sel_pin),
		.reset_pin      (master_reset_pin),
		.read_strobe_n  (read_strobe_n),
		.write_strobe_n (write_strobe_n),
		.chip_sel_n     (chip_sel_n),
		.pins           (pins)
	);

	hbm_mode_type  mode_ff;
	logic          mode_valid_ff;
	hbm_cycle_type cycle_ff;
	hbm_cycle_type nxt_cycle;
	logic          ext_reset;
	logic          reset_seen_ff;
	logic          uart_reset_ff;
	logic          rd_req;
	logic          wr_req;
	logic [NUM_CHAN-1:0] irq_ff;
	logic [NUM_CHAN-1:0] ioe_ff;
	logic          dev_irq_ff;
	logic          mode_dir;

	assign mode_dir = (mode_ff == hbm_mode_direction);

	// Reset pin meaning depends on latched mode
	function automatic logic reset_active(input logic pin,
		input logic dir_mode);
		reset_active = dir_mode ? ~pin : pin;
	endfunction

	// Mode captured at release and at each external reset seen while the cycle is idle
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			mode_ff       <= hbm_mode_strobes;
			mode_valid_ff <= 1'h0;
		end else if (!mode_valid_ff ||
			(ext_reset && cycle_ff == hbm_st_idle)) begin
			mode_ff       <= (pins.mode_sel == MODE_SEL_WIDE) ?
				hbm_mode_strobes : hbm_mode_direction;
			mode_valid_ff <= 1'h1;
		end
	end

	assign ext_reset = mode_valid_ff &&
		reset_active(pins.reset_pin, mode_dir);

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			reset_seen_ff <= 1'h0;
			uart_reset_ff <= 1'h1;
		end else begin
			reset_seen_ff <= ext_reset;
			uart_reset_ff <= ~mode_valid_ff | ext_reset | reset_seen_ff;
		end
	end
	assign uart_reset = uart_reset_ff;

	// Decode of host request per mode
	always_comb begin
		rd_req = 1'h0;
		wr_req = 1'h0;
		if (pins.chip_sel_n == STROBE_ACTIVE) begin
			if (mode_dir) begin
				rd_req = (pins.write_dir == DIR_READ);
				wr_req = (pins.write_dir != DIR_READ);
			end else begin
				rd_req = (pins.read_n == STROBE_ACTIVE);
				wr_req = (pins.write_dir == STROBE_ACTIVE);
			end
		end
	end

	always_comb begin
		nxt_cycle = cycle_ff;
		case (cycle_ff)
			hbm_st_idle: begin
				if (rd_req)
					nxt_cycle = hbm_st_read;
				else if (wr_req)
					nxt_cycle = hbm_st_write;
			end
			hbm_st_read: begin
				if (!rd_req)
					nxt_cycle = hbm_st_idle;
			end
			hbm_st_write: begin
				if (!wr_req)
					nxt_cycle = hbm_st_idle;
			end
			default: nxt_cycle = hbm_st_idle;
		endcase
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst)
			cycle_ff <= hbm_st_idle;
		else if (uart_reset_ff)
			cycle_ff <= hbm_st_idle;
		else
			cycle_ff <= nxt_cycle;
	end

	// One pulse per access, at the strobe's leading edge
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			reg_read_pulse  <= 1'h0;
			reg_write_pulse <= 1'h0;
		end else begin
			reg_read_pulse  <= !uart_reset_ff && cycle_ff == hbm_st_idle &&
				rd_req;
			reg_write_pulse <= !uart_reset_ff && cycle_ff == hbm_st_idle &&
				!rd_req && wr_req;
		end
	end
	assign cycle_active = (cycle_ff != hbm_st_idle);
	assign mode_direction = mode_dir;

	// Registered request and enable per channel
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			irq_ff     <= '0;
			ioe_ff     <= '0;
			dev_irq_ff <= 1'h0;
		end else begin
			irq_ff     <= chan_irq_req & ~{NUM_CHAN{uart_reset_ff}};
			ioe_ff     <= interrupt_output_enable_bit &
				~{NUM_CHAN{uart_reset_ff}};
			dev_irq_ff <= |(chan_irq_req & interrupt_output_enable_bit) &
				~uart_reset_ff;
		end
	end

	// Channel A pin: per-channel or shared open-drain
	always_comb begin
		if (mode_dir) begin
			chan_a_interrupt_out_o  = IRQ_ACTIVE_LOW;
			chan_a_interrupt_out_oe = dev_irq_ff;
		end else begin
			chan_a_interrupt_out_o  = irq_ff[CHAN_A];
			chan_a_interrupt_out_oe = ioe_ff[CHAN_A];
		end
	end

	// Channel B pin only used in strobe mode
	always_comb begin
		if (mode_dir) begin
			chan_b_interrupt_out_o  = 1'h0;
			chan_b_interrupt_out_oe = 1'h0;
		end else begin
			chan_b_interrupt_out_o  = irq_ff[CHAN_B];
			chan_b_interrupt_out_oe = ioe_ff[CHAN_B];
		end
	end

	// User outputs mirror enable, active low
	assign chan_a_user_output_two = ioe_ff[CHAN_A] ?
		USER_OUT_LOW : USER_OUT_HIGH;
	assign chan_b_user_output_two = ioe_ff[CHAN_B] ?
		USER_OUT_LOW : USER_OUT_HIGH;
endmodule
`default_nettype wire

// ### testbench/hbm_host_model.sv
// Host bus model driving strobes, direction and chip select.
// Assumes dir_mode follows the latched mode of the device.
`timescale 1ns/1ps
`default_nettype none
module hbm_host_model (
	input  wire logic mclk,
	input  wire logic dir_mode,
	output logic      read_strobe_n,
	output logic      write_strobe_n,
	output logic      chip_sel_n
);
	initial begin
		read_strobe_n = 1'h1;
		write_strobe_n = 1'h1;
		chip_sel_n = 1'h1;
	end
	task automatic access(input logic rd, input logic bad);
		@(posedge mclk);
		chip_sel_n <= 1'h0;
		if (dir_mode) begin
			write_strobe_n <= rd;
			read_strobe_n <= ~bad;
		end else if (rd)
			read_strobe_n <= 1'h0;
		else
			write_strobe_n <= 1'h0;
		repeat (8) @(posedge mclk);
		chip_sel_n <= 1'h1;
		read_strobe_n <= 1'h1;
		write_strobe_n <= 1'h1;
		repeat (6) @(posedge mclk);
	endtask
endmodule
`default_nettype wire

// ### testbench/hbm_top_assertions.sv
// Checker for the interrupt pins and read access pulse of hbm_top.
// Assumes enable bits stay 0 while in reset or at mode change.
`timescale 1ns/1ps
`default_nettype none
module hbm_top_assertions
	import hbm_pkg::*;
(
	input wire logic                mclk,
	input wire logic                rst,
	input wire logic [NUM_CHAN-1:0] interrupt_output_enable_bit,
	input wire logic [NUM_CHAN-1:0] chan_irq_req,
	input wire logic                chan_a_interrupt_out_o,
	input wire logic                chan_a_interrupt_out_oe,
	input wire logic                chan_b_interrupt_out_o,
	input wire logic                chan_b_interrupt_out_oe,
	input wire logic                chan_a_user_output_two,
	input wire logic                chan_b_user_output_two,
	input wire logic                mode_direction,
	input wire logic                reg_read_pulse
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	wire logic [1:0] en = interrupt_output_enable_bit;
	wire logic [1:0] rq = chan_irq_req;
	wire logic       md = mode_direction;
	sequence s_once;
		reg_read_pulse ##1 !reg_read_pulse;
	endsequence
	AST_A_ON: assert property (!md && $past(en[0]) |-> chan_a_interrupt_out_oe
		&& chan_a_interrupt_out_o == $past(rq[0]) && !chan_a_user_output_two)
		else $error("chan a enable wrong");
	AST_A_OFF: assert property (!md && !$past(en[0]) |-> !chan_a_interrupt_out_oe)
		else $error("chan a not released");
	AST_U_A: assert property (!$past(en[0]) |-> chan_a_user_output_two)
		else $error("chan a user out low");
	AST_B_ON: assert property (!md && $past(en[1]) |-> chan_b_interrupt_out_oe
		&& chan_b_interrupt_out_o == $past(rq[1]) && !chan_b_user_output_two)
		else $error("chan b enable wrong");
	AST_B_OFF: assert property (!$past(en[1]) |-> !chan_b_interrupt_out_oe
		&& chan_b_user_output_two) else $error("chan b not released");
	AST_OD: assert property (md |-> !chan_a_interrupt_out_o)
		else $error("shared irq drove high");
	AST_OD_ON: assert property (md && $past(|(en & rq)) |-> chan_a_interrupt_out_oe)
		else $error("shared irq not pulled");
	AST_NB: assert property (md |-> !chan_b_interrupt_out_oe)
		else $error("chan b driven");
	AST_PULSE: assert property (reg_read_pulse |-> s_once)
		else $error("read pulse too long");
endmodule
bind hbm_top hbm_top_assertions chk_u (.mclk(mclk), .rst(rst),
	.interrupt_output_enable_bit(interrupt_output_enable_bit),
	.chan_irq_req(chan_irq_req), .chan_a_interrupt_out_o(chan_a_interrupt_out_o),
	.chan_a_interrupt_out_oe(chan_a_interrupt_out_oe),
	.chan_b_interrupt_out_o(chan_b_interrupt_out_o),
	.chan_b_interrupt_out_oe(chan_b_interrupt_out_oe),
	.chan_a_user_output_two(chan_a_user_output_two),
	.chan_b_user_output_two(chan_b_user_output_two),
	.mode_direction(mode_direction), .reg_read_pulse(reg_read_pulse));
`default_nettype wire

// ### testbench/tb.sv
// Testbench for hbm_top with a host bus model.
// Assumes a 125 MHz mclk and no other clock.
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic       mclk, rst, msel, mrst, rd_n, wr_n, cs_n;
	logic [1:0] ioe, req;
	logic       a_o, a_oe, b_o, b_oe, ua2, ub2, mdir, urst, rdp, wrp, cyc;
	int         fail_count, checked, n_rd, n_wr;
	always #4 mclk = ~mclk;
	always @(posedge mclk) begin
		n_rd <= n_rd + (rdp === 1'h1);
		n_wr <= n_wr + (wrp === 1'h1);
	end
	hbm_top dut_u (.mclk(mclk), .rst(rst), .mode_sel_pin(msel),
		.master_reset_pin(mrst), .read_strobe_n(rd_n), .write_strobe_n(wr_n),
		.chip_sel_n(cs_n), .interrupt_output_enable_bit(ioe), .chan_irq_req(req),
		.chan_a_interrupt_out_o(a_o), .chan_a_interrupt_out_oe(a_oe),
		.chan_b_interrupt_out_o(b_o), .chan_b_interrupt_out_oe(b_oe),
		.chan_a_user_output_two(ua2), .chan_b_user_output_two(ub2),
		.mode_direction(mdir), .uart_reset(urst), .reg_read_pulse(rdp),
		.reg_write_pulse(wrp), .cycle_active(cyc));
	hbm_host_model host_u (.mclk(mclk), .dir_mode(mdir), .read_strobe_n(rd_n),
		.write_strobe_n(wr_n), .chip_sel_n(cs_n));
	task automatic chk(input string nm, input logic [3:0] e, input logic [3:0] g);
		checked++;
		if (g !== e) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic test_irq(input logic dm);
		logic [3:0] v;
		for (int i = 0; i < 16; i++) begin
			v = i[3:0];
			@(posedge mclk);
			ioe <= v[1:0];
			req <= v[3:2];
			repeat (2) @(posedge mclk);
			#1;
			chk("user outs", {2'h0, ~v[1:0]}, {2'h0, ub2, ua2});
			if (dm)
				chk("irq dir", {|(v[1:0] & v[3:2]), 3'h0},
					{a_oe, a_oe & a_o, b_oe, b_oe & b_o});
			else
				chk("irq strobe", {v[0], v[0] & v[2], v[1], v[1] & v[3]},
					{a_oe, a_oe & a_o, b_oe, b_oe & b_o});
		end
		ioe <= 2'h0;
		repeat (2) @(posedge mclk);
		$display("test_irq done");
	endtask
	task automatic test_acc(input logic rd, input logic bad);
		int r0;
		int w0;
		r0 = n_rd;
		w0 = n_wr;
		host_u.access(rd, bad);
		chk("pulses", {1'h0, rd, ~rd, 1'h0},
			{1'h0, (n_rd - r0) == 1, (n_wr - w0) == 1, cyc});
		$display("test_acc done");
	endtask
	task automatic print_verdict;
		$display("checked %0d fail_count %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		#20000;
		fail_count++;
		print_verdict();
	end
	initial begin
		{mclk, rst, msel, mrst, ioe, req} = 8'h60;
		repeat (10) @(posedge mclk);
		rst <= 1'h0;
		repeat (8) @(posedge mclk);
		chk("mode", 4'h0, {3'h0, mdir});
		test_irq(1'h0);
		test_acc(1'h1, 1'h0);
		test_acc(1'h0, 1'h0);
		msel <= 1'h0;
		repeat (6) @(posedge mclk);
		chk("mode held", 4'h0, {3'h0, mdir});
		mrst <= 1'h1;
		repeat (4) @(posedge mclk);
		repeat (10) @(posedge mclk);
		chk("relatch", 4'h2, {2'h0, mdir, urst});
		mrst <= 1'h0;
		repeat (6) @(posedge mclk);
		chk("low reset", 4'h3, {2'h0, mdir, urst});
		mrst <= 1'h1;
		repeat (10) @(posedge mclk);
		test_irq(1'h1);
		test_acc(1'h1, 1'h0);
		test_acc(1'h0, 1'h1);
		print_verdict();
	end
endmodule
`default_nettype wire
